//--- hw/legacy_io_coproc_glue.sv
// Behaviour
// - busy output latches coprocessor busy or error
// - busy toggles from toggle input without coprocessor
// - active-high coprocessor interrupt for line 13
// - error output follows input until ROM select
// - speaker data is timer2 and enable bit
// - emulation only while fast input high
// - D1h then data to 60h sets gate
// - gate output reproduces keyboard controller gate
// - port 60h read: reset bit0, gate bit1
// - FEh to 64h pulses emulated cpu reset
// - reset pulse shaped like controller reset
// - config bit6 immediate, otherwise 2us delay
// - port 61h bits 0-3 rw, 4-7 status
// - config mirrored_config_index write-only, high nibble used
`timescale 1ns/10ps
`include "glue_consts.svh"

module legacy_io_coproc_glue (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire glue_pkg::io_req_type  ioReq,
  output logic [7:0]                 ioReadData,
  output logic                       ioReadOe,
  input  wire logic                  coprocErrorIn_n,
  input  wire logic                  coprocBusyIn_n,
  input  wire logic                  busyToggleCtl_n,
  input  wire logic                  resetPhase4_n,
  input  wire logic                  biosRomSelect_n,
  input  wire logic                  timer2Output,
  input  wire logic                  channelCheckIn_n,
  input  wire logic                  parityCheckEnableIn_n,
  input  wire logic                  memParityError,
  input  wire logic                  refreshActive_n,
  input  wire logic                  emulationEnable,
  output logic                       cpuBusyOut_n,
  output logic                       cpuErrorOut_n,
  output logic                       coprocResetOut,
  output logic                       coprocIrqOut,
  output logic                       nmiOut,
  output logic                       speakerDataOut,
  output logic                       timer2GateOut,
  output logic                       addr20GateOut,
  output logic                       emulatedCpuResetOut_n,
  output logic                       kbdCtrlSelect_n
);
  import glue_pkg::*;

  localparam logic [7:0] DelayCycles = 8'(`RESET_DELAY_CYCLES);
  localparam logic [7:0] PulseCycles = 8'(`RESET_PULSE_CYCLES);

  logic            rstMeta_reg;
  logic            rstSync_reg;
  logic            rst_n;
  logic            writePrev_reg;
  logic            wrStrobe;
  logic            rdActive;
  logic [3:0]      sysCtrl_reg;
  logic            parityLatch_reg;
  logic            channelLatch_reg;
  logic            refreshToggle_reg;
  logic            refreshPrev_reg;
  logic            nmiMask_reg;
  logic [7:0]      cfgIndex_reg;
  logic [3:0]      cfgMirror_reg;
  logic            cmdPending_reg;
  logic            a20_reg;
  reset_state_type rstState_reg;
  reset_state_type rstState_next;
  logic [7:0]      rstCount_reg;
  logic [7:0]      rstCount_next;
  logic            busyLatch_reg;
  logic            errLatch_reg;
  logic            togglePrev_reg;
  logic            errWindow_reg;
  logic [7:0]      readData_next;
  logic            fastResetReq;

  // reset: asynchronous assert, synchronous release
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign rst_n = rstSync_reg;

  // one write strobe per i/o write command
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      writePrev_reg <= 1'b1;
    else
      writePrev_reg <= ioReq.write_n;
  end
  assign wrStrobe = writePrev_reg && !ioReq.write_n;
  assign rdActive = !ioReq.read_n;

  function automatic logic wrTo(input logic [9:0] a);
    wrTo = wrStrobe && (ioReq.addr == a);
  endfunction

  // port 61h control bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sysCtrl_reg <= `SYS_CTRL_RESET;
    else if (wrTo(`PORT_SYS_CTRL))
      sysCtrl_reg <= ioReq.data[3:0];
  end

  // status latches; held clear while their port 61h enable bit is 0, and events latch only while it is 1
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      parityLatch_reg <= 1'b0;
    else if (memParityError && !parityCheckEnableIn_n
             && sysCtrl_reg[`SYS_PARITY_EN])
      parityLatch_reg <= 1'b1;
    else if (!sysCtrl_reg[`SYS_PARITY_EN])
      parityLatch_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      channelLatch_reg <= 1'b0;
    else if (!channelCheckIn_n && sysCtrl_reg[`SYS_CHANNEL_EN])
      channelLatch_reg <= 1'b1;
    else if (!sysCtrl_reg[`SYS_CHANNEL_EN])
      channelLatch_reg <= 1'b0;
  end

  // refresh detect flips once per refresh cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refreshPrev_reg   <= 1'b1;
      refreshToggle_reg <= 1'b0;
    end
    else
    begin
      refreshPrev_reg <= refreshActive_n;
      if (refreshPrev_reg && !refreshActive_n)
        refreshToggle_reg <= !refreshToggle_reg;
    end
  end

  // nmi_mask_port, nmi masked out of reset so garbage cannot fire it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      nmiMask_reg <= `NMI_MASK_RESET;
    else if (wrTo(`PORT_NMI_MASK))
      nmiMask_reg <= ioReq.data[`NMI_MASK_BIT];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      nmiOut <= 1'b0;
    else
      nmiOut <= !nmiMask_reg && (parityLatch_reg || channelLatch_reg);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speakerDataOut <= 1'b0;
      timer2GateOut  <= 1'b0;
    end
    else
    begin
      speakerDataOut <= timer2Output && sysCtrl_reg[`SYS_SPEAKER_EN];
      timer2GateOut  <= sysCtrl_reg[`SYS_TIMER2_GATE];
    end
  end

  // configuration index/data pair; the register itself is write-only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfgIndex_reg  <= 8'h00;
      cfgMirror_reg <= 4'h0;
    end
    else if (wrTo(`PORT_CFG_INDEX))
      cfgIndex_reg <= ioReq.data;
    else if (wrTo(`PORT_CFG_DATA) && cfgIndex_reg == `CFG_MIRROR_INDEX)
      cfgMirror_reg <= ioReq.data[`CFG_MIRROR_MSB:`CFG_MIRROR_LSB];
  end

  // gate A20 emulation: command D1h arms, next data write sets the gate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmdPending_reg <= 1'b0;
      a20_reg        <= 1'b0;
    end
    else if (emulationEnable)
    begin
      if (wrTo(`PORT_KBD_CMD))
        cmdPending_reg <= (ioReq.data == `KBD_CMD_WRITE_OUTPUT);
      else if (wrTo(`PORT_KBD_DATA) && cmdPending_reg)
      begin
        a20_reg        <= ioReq.data[`KBD_STAT_A20];
        cmdPending_reg <= 1'b0;
      end
    end
    else
      cmdPending_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      addr20GateOut <= 1'b0;
    else
      addr20GateOut <= a20_reg;
  end

  // fast reset sequencer
  assign fastResetReq = emulationEnable && wrTo(`PORT_KBD_CMD)
                        && ioReq.data == `KBD_CMD_PULSE_RESET;

  always_comb
  begin
    rstState_next = rstState_reg;
    rstCount_next = rstCount_reg;
    unique case (rstState_reg)
      RST_IDLE:
      begin
        if (fastResetReq)
        begin
          if (cfgMirror_reg[`CFG_FAST_RESET_BIT - `CFG_MIRROR_LSB])
          begin
            rstState_next = RST_PULSE;
            rstCount_next = PulseCycles - 8'd1;
          end
          else
          begin
            rstState_next = RST_DELAY;
            rstCount_next = DelayCycles - 8'd1;
          end
        end
      end
      RST_DELAY:
      begin
        if (rstCount_reg == 8'd0)
        begin
          rstState_next = RST_PULSE;
          rstCount_next = PulseCycles - 8'd1;
        end
        else
          rstCount_next = rstCount_reg - 8'd1;
      end
      RST_PULSE:
      begin
        if (rstCount_reg == 8'd0)
          rstState_next = RST_IDLE;
        else
          rstCount_next = rstCount_reg - 8'd1;
      end
      default:
      begin
        rstState_next = RST_IDLE;
        rstCount_next = 8'd0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstState_reg <= RST_IDLE;
      rstCount_reg <= 8'd0;
    end
    else
    begin
      rstState_reg <= rstState_next;
      rstCount_reg <= rstCount_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      emulatedCpuResetOut_n <= 1'b1;
    else
      emulatedCpuResetOut_n <= !(rstState_next == RST_PULSE);
  end

  // real controller only sees 60h/64h when emulation is off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      kbdCtrlSelect_n <= 1'b1;
    else
      kbdCtrlSelect_n <= !(!emulationEnable
                           && (!ioReq.read_n || !ioReq.write_n)
                           && (ioReq.addr == `PORT_KBD_DATA
                               || ioReq.addr == `PORT_KBD_CMD));
  end

  // coprocessor busy and error latches, cleared by a write to F0h
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busyLatch_reg  <= 1'b0;
      errLatch_reg   <= 1'b0;
      togglePrev_reg <= 1'b1;
    end
    else
    begin
      togglePrev_reg <= busyToggleCtl_n;
      if (!coprocBusyIn_n || !coprocErrorIn_n)
        busyLatch_reg <= 1'b1;
      else if (togglePrev_reg && !busyToggleCtl_n)
        busyLatch_reg <= !busyLatch_reg;
      else if (wrTo(`PORT_COPROC_CLEAR))
        busyLatch_reg <= 1'b0;
      if (!coprocErrorIn_n)
        errLatch_reg <= 1'b1;
      else if (wrTo(`PORT_COPROC_CLEAR))
        errLatch_reg <= 1'b0;
    end
  end

  // error pass-through window: from reset phase 4 to first ROM select
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      errWindow_reg <= 1'b0;
    else if (!resetPhase4_n)
      errWindow_reg <= 1'b1;
    else if (!biosRomSelect_n)
      errWindow_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpuBusyOut_n   <= 1'b1;
      cpuErrorOut_n  <= 1'b1;
      coprocIrqOut   <= 1'b0;
      coprocResetOut <= 1'b0;
    end
    else
    begin
      cpuBusyOut_n   <= !busyLatch_reg;
      cpuErrorOut_n  <= errWindow_reg ? coprocErrorIn_n : 1'b1;
      coprocIrqOut   <= errLatch_reg;
      coprocResetOut <= !resetPhase4_n;
    end
  end

  // read mux
  always_comb
  begin
    readData_next = 8'h00;
    unique case (ioReq.addr)
      `PORT_SYS_CTRL:
        readData_next = {parityLatch_reg, channelLatch_reg, timer2Output,
                         refreshToggle_reg, sysCtrl_reg};
      `PORT_NMI_MASK:
        readData_next = {nmiMask_reg, 7'h00};
      `PORT_KBD_DATA:
        readData_next = {6'h00, a20_reg, !emulatedCpuResetOut_n};
      default:
        readData_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ioReadData <= 8'h00;
      ioReadOe   <= 1'b0;
    end
    else
    begin
      ioReadData <= readData_next;
      ioReadOe   <= rdActive && (ioReq.addr == `PORT_SYS_CTRL
                     || ioReq.addr == `PORT_NMI_MASK
                     || (emulationEnable
                         && ioReq.addr == `PORT_KBD_DATA));
    end
  end

endmodule // legacy_io_coproc_glue

//--- hw/glue_consts.svh
`ifndef GLUE_CONSTS_SVH
`define GLUE_CONSTS_SVH

// i/o port addresses
`define PORT_KBD_DATA        10'h060
`define PORT_SYS_CTRL        10'h061
`define PORT_KBD_CMD         10'h064
`define PORT_NMI_MASK        10'h070
`define PORT_CFG_INDEX       10'h022
`define PORT_CFG_DATA        10'h023
`define PORT_COPROC_CLEAR    10'h0F0

// configuration index and fields
`define CFG_MIRROR_INDEX     8'h21
`define CFG_MIRROR_MSB       7
`define CFG_MIRROR_LSB       4
`define CFG_FAST_RESET_BIT   6

// keyboard controller commands
`define KBD_CMD_WRITE_OUTPUT 8'hD1
`define KBD_CMD_PULSE_RESET  8'hFE

// port 61h fields
`define SYS_TIMER2_GATE      0
`define SYS_SPEAKER_EN       1
`define SYS_PARITY_EN        2
`define SYS_CHANNEL_EN       3
`define SYS_CTRL_RESET       4'h0

// port 60h status fields
`define KBD_STAT_RESET       0
`define KBD_STAT_A20         1

// nmi_mask_port fields
`define NMI_MASK_BIT         7
`define NMI_MASK_RESET       1'b1

// timing
`define CLK_PERIOD_NS        50
`define RESET_DELAY_NS       2000
`define RESET_PULSE_NS       6000
`define RESET_DELAY_CYCLES   (`RESET_DELAY_NS / `CLK_PERIOD_NS)
`define RESET_PULSE_CYCLES   (`RESET_PULSE_NS / `CLK_PERIOD_NS)

`endif

//--- hw/glue_pkg.sv
package glue_pkg;

  typedef struct packed {
    logic [9:0] addr;
    logic       read_n;
    logic       write_n;
    logic [7:0] data;
  } io_req_type;

  typedef enum logic [2:0] {
    RST_IDLE  = 3'b001,
    RST_DELAY = 3'b010,
    RST_PULSE = 3'b100
  } reset_state_type;

endpackage

//--- verif/glue_checker.sv
`timescale 1ns/10ps
`include "glue_consts.svh"

module glue_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic coprocErrorIn_n,
  input wire logic coprocBusyIn_n,
  input wire logic resetPhase4_n,
  input wire logic biosRomSelect_n,
  input wire logic timer2Output,
  input wire logic emulationEnable,
  input wire logic cpuBusyOut_n,
  input wire logic cpuErrorOut_n,
  input wire logic coprocIrqOut,
  input wire logic speakerDataOut,
  input wire logic addr20GateOut,
  input wire logic emulatedCpuResetOut_n,
  input wire logic kbdCtrlSelect_n
);
  logic [2:0] upCnt;
  logic [7:0] lowCnt;

  // hold off until the synchronised reset and output flops have settled
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      upCnt <= 3'h0;
    else if (upCnt != 3'h4)
      upCnt <= upCnt + 3'h1;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      lowCnt <= 8'h00;
    else
      lowCnt <= emulatedCpuResetOut_n ? 8'h00 : lowCnt + 8'h01;

  default clocking @(posedge clk); endclocking
  default disable iff (upCnt != 3'h4);

  property p_busy; !coprocBusyIn_n |-> ##[1:4] !cpuBusyOut_n; endproperty
  a_busy: assert property (p_busy)
    else $error("busy input not latched");
  property p_errBusy; $fell(coprocErrorIn_n) |-> ##[1:4] !cpuBusyOut_n;
  endproperty
  a_errBusy: assert property (p_errBusy)
    else $error("error input not latched into busy");
  property p_irq; $fell(coprocErrorIn_n) |-> ##[1:4] coprocIrqOut;
  endproperty
  a_irq: assert property (p_irq)
    else $error("coprocessor irq missing");
  property p_errWin;
    (!resetPhase4_n && biosRomSelect_n && !coprocErrorIn_n) [*2]
      |-> ##[0:3] !cpuErrorOut_n;
  endproperty
  a_errWin: assert property (p_errWin)
    else $error("error not passed during window");
  property p_pulseW;
    $rose(emulatedCpuResetOut_n) |-> lowCnt == `RESET_PULSE_CYCLES;
  endproperty
  a_pulseW: assert property (p_pulseW)
    else $error("reset pulse width wrong");
  property p_emuOff; !emulationEnable [*3] |-> $stable(addr20GateOut);
  endproperty
  a_emuOff: assert property (p_emuOff)
    else $error("gate moved with emulation off");
  property p_spkOff; !timer2Output [*3] |-> !speakerDataOut; endproperty
  a_spkOff: assert property (p_spkOff)
    else $error("speaker high without timer output");
  property p_kbdSel; emulationEnable [*2] |-> kbdCtrlSelect_n; endproperty
  a_kbdSel: assert property (p_kbdSel)
    else $error("controller selected while emulating");

  c_pulse: cover property ($rose(emulatedCpuResetOut_n));
  c_a20: cover property ($rose(addr20GateOut));
  c_err: cover property (!cpuErrorOut_n);
endmodule // glue_checker

bind legacy_io_coproc_glue glue_checker chk (.*);

//--- verif/coproc_model.sv
`timescale 1ns/10ps

module coproc_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       busyStart,
  input  wire logic [7:0] busyLen,
  input  wire logic       errRaise,
  output logic            coprocBusyIn_n,
  output logic            coprocErrorIn_n
);
  logic [7:0] busyCnt;

  // busy length lets an instruction finish promptly or slowly
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      busyCnt <= 8'h00;
    else if (busyStart)
      busyCnt <= busyLen;
    else if (busyCnt != 8'h00)
      busyCnt <= busyCnt - 8'h01;

  assign coprocBusyIn_n  = (busyCnt == 8'h00);
  assign coprocErrorIn_n = !errRaise;
endmodule // coproc_model

//--- verif/legacy_io_coproc_glue_tb_top.sv
`timescale 1ns/10ps
`include "glue_consts.svh"

module legacy_io_coproc_glue_tb_top;
  import glue_pkg::*;
  io_req_type ioReq;
  logic [7:0] ioReadData, d, busyLen;
  logic       clk, reset_n, ioReadOe, coprocErrorIn_n, coprocBusyIn_n;
  logic       busyToggleCtl_n, resetPhase4_n, biosRomSelect_n;
  logic       timer2Output, channelCheckIn_n, parityCheckEnableIn_n;
  logic       memParityError, emulationEnable, cpuBusyOut_n;
  logic       cpuErrorOut_n, coprocResetOut, coprocIrqOut, nmiOut;
  logic       speakerDataOut, timer2GateOut, addr20GateOut;
  logic       emulatedCpuResetOut_n, kbdCtrlSelect_n, busyStart, errRaise;
  logic       oe, sel, refreshActive_n;
  int         failCount, samplesChecked, n;

  legacy_io_coproc_glue DUT (.*);
  coproc_model partner (.*);

  task automatic ck(string name, logic [7:0] seen, logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
    @(posedge clk);
  endtask

  // ends just past the edge so checked outputs have settled
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(logic [9:0] a, logic [7:0] v);
    @(posedge clk);
    ioReq.addr    <= a;
    ioReq.data    <= v;
    ioReq.write_n <= 1'b0;
    @(posedge clk);
    ioReq.write_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic rd(logic [9:0] a);
    @(posedge clk);
    ioReq.addr   <= a;
    ioReq.read_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 d = ioReadData;
    oe = ioReadOe;
    sel = kbdCtrlSelect_n;
    @(posedge clk);
    ioReq.read_n <= 1'b1;
  endtask

  task automatic waitRst(logic lvl);
    n = 0;
    #1;
    while (emulatedCpuResetOut_n !== lvl && n < 300)
    begin
      @(posedge clk);
      #1 n++;
    end
    // a pulse that never comes is a failure, not a silent skip
    if (n >= 300)
      failCount++;
  endtask

  task automatic printVerdict;
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #200000;
    failCount++;
    printVerdict();
  end

  initial
  begin
    reset_n = 1'b0;
    ioReq = {10'h000, 1'b1, 1'b1, 8'h00};
    {busyToggleCtl_n, resetPhase4_n, biosRomSelect_n, refreshActive_n} = 4'hF;
    {channelCheckIn_n, parityCheckEnableIn_n} = 2'h3;
    {timer2Output, memParityError, emulationEnable} = 3'h0;
    {busyStart, errRaise} = 2'h0;
    busyLen = 8'h06;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    tick(4);
    ck("reset", {addr20GateOut, emulatedCpuResetOut_n, nmiOut}, 8'h02);
    timer2Output <= 1'b1;
    wr(`PORT_SYS_CTRL, 8'hFF);
    tick(2);
    ck("spk", {timer2GateOut, speakerDataOut}, 8'h03);
    rd(`PORT_SYS_CTRL);
    ck("p61", d, 8'h2F);
    ck("p61oe", {7'h00, oe}, 8'h01);
    wr(`PORT_SYS_CTRL, 8'h01);
    tick(2);
    ck("spkoff", {timer2GateOut, speakerDataOut}, 8'h02);
    refreshActive_n <= 1'b0;
    @(posedge clk);
    refreshActive_n <= 1'b1;
    rd(`PORT_SYS_CTRL);
    ck("refresh", d & 8'h10, 8'h10);
    rd(`PORT_NMI_MASK);
    ck("nmimask", d & 8'h80, 8'h80);
    wr(`PORT_NMI_MASK, 8'h00);
    wr(`PORT_SYS_CTRL, 8'h08);
    channelCheckIn_n <= 1'b0;
    tick(3);
    ck("nmichk", nmiOut, 8'h01);
    rd(`PORT_SYS_CTRL);
    ck("chkstat", d & 8'h40, 8'h40);
    wr(`PORT_SYS_CTRL, 8'h00);
    tick(2);
    ck("nmigate", nmiOut, 8'h00);
    channelCheckIn_n <= 1'b1;
    wr(`PORT_NMI_MASK, 8'h80);
    wr(`PORT_SYS_CTRL, 8'h04);
    {parityCheckEnableIn_n, memParityError} <= 2'h1;
    tick(3);
    ck("nmimasked", nmiOut, 8'h00);
    wr(`PORT_NMI_MASK, 8'h00);
    tick(3);
    ck("nmipar", nmiOut, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      emulationEnable <= 1'(i);
      tick(3);
      wr(`PORT_KBD_CMD, `KBD_CMD_WRITE_OUTPUT);
      wr(`PORT_KBD_DATA, 8'h02);
      tick(2);
      ck("a20", addr20GateOut, 8'(i));
      if (i == 0)
      begin
        rd(`PORT_KBD_DATA);
        ck("p60off", {d[5:0], oe, sel}, 8'h00);
      end
    end
    rd(`PORT_KBD_DATA);
    ck("p60", d & 8'h03, 8'h02);
    ck("p60oe", {7'h00, oe}, 8'h01);
    wr(`PORT_KBD_CMD, `KBD_CMD_WRITE_OUTPUT);
    wr(`PORT_KBD_DATA, 8'h00);
    tick(2);
    ck("a20clr", addr20GateOut, 8'h00);
    wr(`PORT_KBD_CMD, `KBD_CMD_WRITE_OUTPUT);
    wr(`PORT_KBD_CMD, 8'hAA);
    wr(`PORT_KBD_DATA, 8'h02);
    tick(2);
    ck("a20disarm", addr20GateOut, 8'h00);
    wr(`PORT_KBD_CMD, `KBD_CMD_PULSE_RESET);
    waitRst(1'b0);
    ck("dly", 8'(n + 1), 8'(`RESET_DELAY_CYCLES));
    rd(`PORT_KBD_DATA);
    ck("p60rst", d & 8'h01, 8'h01);
    waitRst(1'b1);
    wr(`PORT_CFG_INDEX, `CFG_MIRROR_INDEX);
    wr(`PORT_CFG_DATA, 8'h40);
    wr(`PORT_KBD_CMD, `KBD_CMD_PULSE_RESET);
    waitRst(1'b0);
    ck("imm", 8'(n), 8'h00);
    waitRst(1'b1);
    busyStart <= 1'b1;
    @(posedge clk);
    busyStart <= 1'b0;
    tick(10);
    ck("busy", cpuBusyOut_n, 8'h00);
    wr(`PORT_COPROC_CLEAR, 8'h00);
    tick(2);
    ck("clr", cpuBusyOut_n, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      busyToggleCtl_n <= 1'b0;
      repeat (2) @(posedge clk);
      busyToggleCtl_n <= 1'b1;
      tick(2);
      ck("tog", cpuBusyOut_n, 8'(i));
    end
    {resetPhase4_n, errRaise} <= 2'h1;
    tick(4);
    ck("err", {coprocResetOut, cpuErrorOut_n, coprocIrqOut}, 8'h05);
    errRaise <= 1'b0;
    tick(3);
    ck("errfollow", cpuErrorOut_n, 8'h01);
    {resetPhase4_n, biosRomSelect_n} <= 2'h2;
    repeat (2) @(posedge clk);
    {biosRomSelect_n, errRaise} <= 2'h3;
    tick(4);
    ck("errclosed", cpuErrorOut_n, 8'h01);
    errRaise <= 1'b0;
    wr(`PORT_COPROC_CLEAR, 8'h00);
    tick(2);
    ck("irqclr", coprocIrqOut, 8'h00);
    printVerdict();
  end
endmodule // legacy_io_coproc_glue_tb_top
